// ===== hw/mio_pkg.sv
// constants and types for the multi-width serial pin role block
// assumes a 200 MHz system clock sampling a much slower serial link
package mio_pkg;

    // ----------------------------------------------------------------
    // register bit positions
    // ----------------------------------------------------------------
    localparam int CFG1_QUAD_BIT = 1;
    localparam int SR1_SWD_BIT   = 7;
    localparam int CFG2_RST_BIT  = 5;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TRP_NS        = 200;
    localparam int TRP_CYC       = (TRP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TRP_CNT_W     = 8;

    // ----------------------------------------------------------------
    // data path sizes and reset values
    // ----------------------------------------------------------------
    localparam int BYTE_W        = 8;
    localparam int FIFO_DEPTH    = 32;
    localparam int BIT_CNT_W     = 4;
    localparam logic [3:0] LANES_RST = 4'h0;
    localparam logic [7:0] BYTE_RST  = 8'h00;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MIO_W1 = 2'b00,
        MIO_W2 = 2'b01,
        MIO_W4 = 2'b11
    } mio_width_t;

    typedef enum logic [1:0] {
        MIO_DESEL   = 2'b00,
        MIO_SEL     = 2'b01,
        MIO_RST_CHK = 2'b11,
        MIO_RST_HLD = 2'b10
    } mio_state_t;

    typedef struct packed {
        mio_width_t width;
        logic       ddr;
        logic       out_phase;
    } mio_cmd_t;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } mio_pad_t;

endpackage

// ===== hw/mio_sync.sv
// two-stage synchroniser for a group of pin levels
// assumes inputs are asynchronous to clk_sys
`timescale 1ns/1ps
module mio_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q    = meta;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule

// ===== hw/mio_fifo.sv
// byte fifo between the core and the output shifter
// assumes both sides on clk_sys
`timescale 1ns/1ps
module mio_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    always_comb begin
        in_ready    = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
        out_valid   = wr_ptr != rd_ptr;
        out_data    = mem[rd_ptr[AW-1:0]];
        push        = in_valid & in_ready;
        pop         = out_valid & out_ready;
        next_wr_ptr = wr_ptr + (AW+1)'(push);
        next_rd_ptr = rd_ptr + (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end
endmodule

// ===== hw/mio_pins.sv
// pin role selection and lane shifting for the multi-width serial port
// assumes pins arrive asynchronously; core side runs on clk_sys
`timescale 1ns/1ps
module mio_pins
    import mio_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        sck_pin,
    input  wire logic        cs_n_pin,
    input  wire logic [3:0]  io_in,
    output mio_pad_t         pad,
    input  wire logic [7:0]  cfg1_volatile_reg,
    input  wire logic [7:0]  status1_nonvolatile_reg,
    input  wire logic [7:0]  cfg2_volatile_reg,
    input  wire mio_cmd_t    cmd,
    input  wire logic        write_registers_cmd,
    input  wire logic        write_any_register_cmd,
    input  wire logic        wrany_hits_sr1_cfg1,
    output logic             reg_write_ignore,
    output logic             wp_n_level,
    output logic             selected,
    output logic             hw_reset,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    output logic [7:0]       rx_data,
    output logic             rx_valid,
    output logic             tx_underrun
);

    // ----------------------------------------------------------------
    // pin synchronisation and edge finding
    // ----------------------------------------------------------------
    logic [5:0] pins_s;
    logic       sck_s;
    logic       cs_n_s;
    logic [3:0] io_s;
    logic       sck_d;
    logic       next_sck_d;
    logic       sck_rise;
    logic       sck_fall;

    mio_sync #(.W(6)) u_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .d       ({sck_pin, ~cs_n_pin, ~io_in}),   // idle-high pins kept inverted
        .q       (pins_s)
    );

    always_comb begin
        sck_s      = pins_s[5];
        cs_n_s     = ~pins_s[4];
        io_s       = ~pins_s[3:0];
        next_sck_d = sck_s;
        sck_rise   = sck_s & ~sck_d;
        sck_fall   = ~sck_s & sck_d;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sck_d <= 1'b0;
        end else begin
            sck_d <= next_sck_d;
        end
    end

    // ----------------------------------------------------------------
    // pin roles from configuration
    // ----------------------------------------------------------------
    logic quad_en;
    logic swd;
    logic rst_en;
    logic wp_role;
    logic rst_role;
    logic sel_now;

    always_comb begin
        quad_en  = cfg1_volatile_reg[CFG1_QUAD_BIT];
        swd      = status1_nonvolatile_reg[SR1_SWD_BIT];
        rst_en   = cfg2_volatile_reg[CFG2_RST_BIT];
        sel_now  = ~cs_n_s;
        wp_role  = ~quad_en & swd;
        rst_role = rst_en & (~quad_en | cs_n_s);
    end

    // ----------------------------------------------------------------
    // selection and hardware reset detection
    // ----------------------------------------------------------------
    mio_state_t           state;
    mio_state_t           next_state;
    logic [TRP_CNT_W-1:0] rst_cnt;
    logic [TRP_CNT_W-1:0] next_rst_cnt;
    logic                 next_hw_reset;
    logic                 rst_low;

    always_comb begin
        next_state    = state;
        next_rst_cnt  = rst_cnt;
        next_hw_reset = 1'b0;
        rst_low       = cs_n_s & rst_role & ~io_s[3];
        unique case (state)
            MIO_DESEL: begin
                if (sel_now) begin
                    next_state = MIO_SEL;
                end else if (rst_low) begin
                    next_state   = MIO_RST_CHK;
                    next_rst_cnt = TRP_CNT_W'(1);
                end
            end
            MIO_SEL: begin
                if (!sel_now) begin
                    next_state = MIO_DESEL;
                end
            end
            MIO_RST_CHK: begin
                if (!rst_low) begin
                    next_state = sel_now ? MIO_SEL : MIO_DESEL;
                end else if (rst_cnt == TRP_CNT_W'(TRP_CYC)) begin
                    next_state    = MIO_RST_HLD;
                    next_hw_reset = 1'b1;
                end else begin
                    next_rst_cnt = rst_cnt + TRP_CNT_W'(1);
                end
            end
            MIO_RST_HLD: begin
                if (!rst_low) begin
                    next_state = sel_now ? MIO_SEL : MIO_DESEL;
                end
            end
            default: begin
                next_state = MIO_DESEL;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state    <= MIO_DESEL;
            rst_cnt  <= '0;
            hw_reset <= 1'b0;
        end else begin
            state    <= next_state;
            rst_cnt  <= next_rst_cnt;
            hw_reset <= next_hw_reset;
        end
    end

    // ----------------------------------------------------------------
    // write protect and register write filtering
    // ----------------------------------------------------------------
    logic next_wp_n_level;
    logic next_reg_write_ignore;
    logic reg_write;

    always_comb begin
        // host keeps the pin firm during the write, so one sample suffices
        next_wp_n_level = wp_role ? io_s[2] : 1'b1;
        reg_write       = write_registers_cmd
                        | (write_any_register_cmd & wrany_hits_sr1_cfg1);
        next_reg_write_ignore = sel_now & reg_write & wp_role
                              & ~io_s[2];
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wp_n_level       <= 1'b1;
            reg_write_ignore <= 1'b0;
        end else begin
            wp_n_level       <= next_wp_n_level;
            reg_write_ignore <= next_reg_write_ignore;
        end
    end

    // ----------------------------------------------------------------
    // lane width helpers
    // ----------------------------------------------------------------
    logic [BIT_CNT_W-1:0] step;
    logic [3:0]           lane_mask;

    always_comb begin
        unique case (cmd.width)
            MIO_W1: begin
                step      = BIT_CNT_W'(1);
                lane_mask = 4'h2;
            end
            MIO_W2: begin
                step      = BIT_CNT_W'(2);
                lane_mask = 4'h3;
            end
            MIO_W4: begin
                step      = BIT_CNT_W'(4);
                lane_mask = quad_en ? 4'hf : 4'h3;
            end
            default: begin
                step      = BIT_CNT_W'(1);
                lane_mask = 4'h2;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // receive shifter, sampled on rising serial clock
    // ----------------------------------------------------------------
    logic [7:0]           rx_sh;
    logic [BIT_CNT_W-1:0] rx_cnt;
    logic [7:0]           next_rx_sh;
    logic [BIT_CNT_W-1:0] next_rx_cnt;
    logic [7:0]           next_rx_data;
    logic                 next_rx_valid;
    logic [BIT_CNT_W-1:0] rx_sum;

    always_comb begin
        next_rx_sh    = rx_sh;
        next_rx_cnt   = rx_cnt;
        next_rx_data  = rx_data;
        next_rx_valid = 1'b0;
        rx_sum        = rx_cnt + step;
        if (!sel_now) begin
            next_rx_cnt = '0;
        end else if (sck_rise && !cmd.out_phase) begin
            unique case (cmd.width)
                MIO_W1:  next_rx_sh = {rx_sh[6:0], io_s[0]};
                MIO_W2:  next_rx_sh = {rx_sh[5:0], io_s[1:0]};
                MIO_W4:  next_rx_sh = {rx_sh[3:0], io_s[3:0]};
                default: next_rx_sh = rx_sh;
            endcase
            if (rx_sum == BIT_CNT_W'(BYTE_W)) begin
                next_rx_cnt   = '0;
                next_rx_data  = next_rx_sh;
                next_rx_valid = 1'b1;
            end else begin
                next_rx_cnt = rx_sum;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rx_sh    <= BYTE_RST;
            rx_cnt   <= '0;
            rx_data  <= BYTE_RST;
            rx_valid <= 1'b0;
        end else begin
            rx_sh    <= next_rx_sh;
            rx_cnt   <= next_rx_cnt;
            rx_data  <= next_rx_data;
            rx_valid <= next_rx_valid;
        end
    end

    // ----------------------------------------------------------------
    // transmit fifo and shifter, driven after the output edge
    // ----------------------------------------------------------------
    logic [7:0]           fifo_data;
    logic                 fifo_valid;
    logic                 fifo_pop;
    logic [7:0]           tx_sh;
    logic [BIT_CNT_W-1:0] tx_left;
    logic [3:0]           out_q;
    logic [7:0]           next_tx_sh;
    logic [BIT_CNT_W-1:0] next_tx_left;
    logic [3:0]           next_out_q;
    logic                 next_tx_underrun;
    logic                 out_edge;
    logic                 driving;
    logic [7:0]           src;

    mio_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .in_data   (tx_data),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    always_comb begin
        driving          = sel_now & cmd.out_phase;
        out_edge         = sck_fall | (cmd.ddr & sck_rise);
        next_tx_sh       = tx_sh;
        next_tx_left     = tx_left;
        next_out_q       = out_q;
        next_tx_underrun = 1'b0;
        fifo_pop         = 1'b0;
        src              = (tx_left == '0) ? fifo_data : tx_sh;
        if (!driving) begin
            next_tx_left = '0;
        end else if (out_edge) begin
            if (tx_left == '0 && !fifo_valid) begin
                next_tx_underrun = 1'b1;
            end else begin
                fifo_pop     = (tx_left == '0);
                next_tx_left = ((tx_left == '0) ? BIT_CNT_W'(BYTE_W) : tx_left) - step;
                unique case (cmd.width)
                    MIO_W1: begin
                        next_out_q = {2'b00, src[7], 1'b0};
                        next_tx_sh = {src[6:0], 1'b0};
                    end
                    MIO_W2: begin
                        next_out_q = {2'b00, src[7:6]};
                        next_tx_sh = {src[5:0], 2'b00};
                    end
                    MIO_W4: begin
                        next_out_q = src[7:4];
                        next_tx_sh = {src[3:0], 4'h0};
                    end
                    default: begin
                        next_out_q = out_q;
                        next_tx_sh = tx_sh;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_sh       <= BYTE_RST;
            tx_left     <= '0;
            out_q       <= LANES_RST;
            tx_underrun <= 1'b0;
        end else begin
            tx_sh       <= next_tx_sh;
            tx_left     <= next_tx_left;
            out_q       <= next_out_q;
            tx_underrun <= next_tx_underrun;
        end
    end

    // ----------------------------------------------------------------
    // pad drive
    // ----------------------------------------------------------------
    always_comb begin
        selected = sel_now;
        pad.out  = out_q;
        pad.oe   = driving ? lane_mask : LANES_RST;
    end

endmodule

// ===== bench/mio_pins_asserts.sv
// concurrent checks on the pin role block, bound onto mio_pins
// assumes one clk_sys domain with async active-low resetn
`timescale 1ns/1ps
module mio_pins_asserts
    import mio_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       cs_n_pin,
    input wire logic [3:0] io_in,
    input wire mio_pad_t   pad,
    input wire logic [7:0] cfg1_volatile_reg,
    input wire logic [7:0] status1_nonvolatile_reg,
    input wire logic [7:0] cfg2_volatile_reg,
    input wire mio_cmd_t   cmd,
    input wire logic       write_registers_cmd,
    input wire logic       write_any_register_cmd,
    input wire logic       wrany_hits_sr1_cfg1,
    input wire logic       reg_write_ignore,
    input wire logic       wp_n_level,
    input wire logic       selected,
    input wire logic       hw_reset
);
    logic [7:0] low_run;
    logic [1:0] since_rst;
    logic       quad;
    logic       wp_role;
    logic       out_ok;
    assign quad    = cfg1_volatile_reg[CFG1_QUAD_BIT];
    assign wp_role = !quad && status1_nonvolatile_reg[SR1_SWD_BIT];
    assign out_ok  = selected && cmd.out_phase;
    // ----------------------------------------------------------------
    // reset request length and settle count
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            low_run   <= 8'h00;
            since_rst <= 2'h0;
        end else begin
            low_run   <= (cs_n_pin && !io_in[3] && cfg2_volatile_reg[CFG2_RST_BIT])
                       ? low_run + {7'h00, low_run != 8'hff} : 8'h00;
            since_rst <= since_rst + {1'b0, since_rst != 2'h3};
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    AST_SEL_SYNC: assert property (since_rst == 2'h3 |-> selected == !$past(cs_n_pin, 2))
        else $error("selected does not follow chip select");
    AST_OE_IDLE: assert property (!out_ok |-> pad.oe == 4'h0)
        else $error("lane driven outside output phase");
    AST_OE_W1: assert property (out_ok && cmd.width == MIO_W1 |-> pad.oe == 4'h2)
        else $error("single output not on second lane");
    AST_OE_W2: assert property (out_ok && (cmd.width == MIO_W2 ||
        (cmd.width == MIO_W4 && !quad)) |-> pad.oe == 4'h3)
        else $error("dual lanes enable wrong");
    AST_OE_W4: assert property (out_ok && cmd.width == MIO_W4 && quad |-> pad.oe == 4'hf)
        else $error("quad lanes enable wrong");
    AST_WP_FOLLOW: assert property ((wp_role && $stable(io_in[2]))[*4] |=>
        wp_n_level == $past(io_in[2]))
        else $error("write protect level not followed");
    AST_WP_OFF: assert property (!wp_role |=> wp_n_level)
        else $error("write protect active outside its role");
    AST_RWI_CAUSE: assert property (reg_write_ignore |-> $past(selected && wp_role &&
        (write_registers_cmd || (write_any_register_cmd && wrany_hits_sr1_cfg1))))
        else $error("register write dropped without cause");
    AST_RWI_SET: assert property ((selected && wp_role && write_registers_cmd
        && !io_in[2])[*4] |=> reg_write_ignore)
        else $error("protected register write not dropped");
    AST_RST_MIN: assert property (hw_reset |-> low_run >= TRP_CYC)
        else $error("reset recognised before full pulse time");
    AST_RST_DUE: assert property (low_run == TRP_CYC + 1 |-> ##[1:8] hw_reset)
        else $error("reset not recognised");
    AST_RST_PULSE: assert property (hw_reset |=> !hw_reset)
        else $error("reset pulse too long");
    AST_NO_RST_SEL: assert property ((!cs_n_pin)[*4] |-> !hw_reset)
        else $error("reset while selected");
    COV_RST: cover property (hw_reset);
    COV_RWI: cover property (reg_write_ignore);
    COV_QUAD: cover property (pad.oe == 4'hf);
endmodule

bind mio_pins mio_pins_asserts mio_pins_asserts_inst (.*);

// ===== bench/mio_host_model.sv
// host controller model: serial clock, select and lane drive
// assumes the bench resolves lanes; released lanes 0, 1 show the inverse
`timescale 1ns/1ps
module mio_host_model (
    input  wire logic [3:0] io_bus,
    output logic            sck_pin,
    output logic            cs_n_pin,
    output logic [3:0]      host_io,
    output logic [3:0]      host_oe
);
    localparam realtime HALF = 62.5;
    initial begin
        sck_pin  = 1'b0;
        cs_n_pin = 1'b1;
        host_io  = 4'hf;
        host_oe  = 4'hc;
    end
    // protect and reset lanes held firm while not a data lane
    task automatic side_pins(input logic wp, input logic rst);
        host_io[3:2] = {rst, wp};
        host_oe[3:2] = 2'b11;
    endtask
    // reset lane driven high before deselect so no reset is seen
    task automatic frame(input logic sel);
        #7.3;
        host_io[3] = 1'b1;
        host_oe[3] = 1'b1;
        cs_n_pin   = ~sel;
        #100;
    endtask
    // lanes set while clock low, msb first, taken on rising edge
    task automatic send(input logic [7:0] b, input int lanes);
        host_oe = (lanes == 4) ? 4'hf : {host_oe[3:2], lanes == 2, 1'b1};
        repeat (8 / lanes) begin
            case (lanes)
                1: host_io[0] = b[7];
                2: host_io[1:0] = b[7:6];
                default: host_io = b[7:4];
            endcase
            b = b << lanes;
            #HALF sck_pin = 1'b1;
            #HALF sck_pin = 1'b0;
        end
    endtask
    // device drives after each output edge; sampled half a period later
    task automatic recv(input int lanes, input logic ddr, output logic [7:0] b);
        host_io[1:0] = ~host_io[1:0];
        host_oe = (lanes == 4) ? 4'h0 : {host_oe[3:2], 2'b00};
        repeat (ddr ? 8 / lanes : 16 / lanes) begin
            sck_pin = ~sck_pin;
            #HALF;
            if (ddr || !sck_pin) begin
                case (lanes)
                    1: b = {b[6:0], io_bus[1]};
                    2: b = {b[5:0], io_bus[1:0]};
                    default: b = {b[3:0], io_bus};
                endcase
            end
        end
    endtask
endmodule

// ===== bench/mio_pins_tb_top.sv
// self-checking bench for mio_pins driven by the host model
// assumes lanes resolve here: device, then host, then pull-up on 2 and 3
`timescale 1ns/1ps
module mio_pins_tb_top;
    import mio_pkg::*;
    localparam int LIMIT = 20000;
    logic       clk_sys = 1'b0;
    logic       resetn = 1'b0;
    logic       sck_pin, cs_n_pin, reg_write_ignore, wp_n_level, selected, hw_reset;
    logic       write_registers_cmd, write_any_register_cmd, wrany_hits_sr1_cfg1;
    logic       tx_valid, tx_ready, rx_valid, tx_underrun;
    logic [3:0] io_in, host_io, host_oe;
    logic [7:0] cfg1_volatile_reg, status1_nonvolatile_reg, cfg2_volatile_reg;
    logic [7:0] tx_data, rx_data, rx_last;
    mio_pad_t   pad;
    mio_cmd_t   cmd;
    int         fails, checks, cyc, rx_cnt, und_cnt, rst_cnt;
    always #2.5 clk_sys = ~clk_sys;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io_in[i] = pad.oe[i] ? pad.out[i] : (host_oe[i] || i < 2) ? host_io[i] : 1'b1;
        end
    end
    mio_pins mio_pins_inst (.*);
    mio_host_model mio_host_model_inst (.io_bus(io_in), .sck_pin(sck_pin), .cs_n_pin(cs_n_pin),
        .host_io(host_io), .host_oe(host_oe));
    // ----------------------------------------------------------------
    // monitors, checks and closing report
    // ----------------------------------------------------------------
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (rx_valid === 1'b1) begin
            rx_last <= rx_data;
            rx_cnt  <= rx_cnt + 1;
        end
        und_cnt <= und_cnt + int'(tx_underrun === 1'b1);
        rst_cnt <= rst_cnt + int'(hw_reset === 1'b1);
        if (cyc == LIMIT) begin
            fails = fails + 1;
            stop_test();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
            fails++;
        end
    endtask
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    function automatic logic [7:0] exp_oe(input mio_width_t w, input logic q);
        return (w == MIO_W1) ? 8'h02 : (w == MIO_W4 && q) ? 8'h0f : 8'h03;
    endfunction
    function automatic logic [7:0] exp_ign(input int k);
        return {7'h00, !k[2] && k[1] && !k[0] && k < 16};
    endfunction
    task automatic push(input logic [7:0] b);
        @(negedge clk_sys);
        tx_data  = b;
        tx_valid = 1'b1;
        @(negedge clk_sys);
        tx_valid = 1'b0;
    endtask
    initial begin
        logic [7:0] b, got;
        logic [7:0] q[$];
        int         n;
        mio_width_t wd[3];
        int         ln[3];
        wd = '{MIO_W1, MIO_W2, MIO_W4};
        ln = '{1, 2, 4};
        {cfg1_volatile_reg, status1_nonvolatile_reg, cfg2_volatile_reg} = 24'h000000;
        {write_registers_cmd, write_any_register_cmd, wrany_hits_sr1_cfg1} = 3'h0;
        cmd = '{MIO_W1, 1'b0, 1'b0};
        tx_data = 8'h00;
        tx_valid = 1'b0;
        void'($urandom(61));
        repeat (5) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (4) @(negedge clk_sys);
        mio_host_model_inst.side_pins(1'b1, 1'b1);
        for (int k = 0; k < 3; k++) begin
            cfg1_volatile_reg = {6'h00, k == 2, 1'b0};
            cmd = '{wd[k], 1'b0, 1'b0};
            b = 8'($urandom);
            n = rx_cnt;
            mio_host_model_inst.frame(1'b1);
            mio_host_model_inst.send(b, ln[k]);
            repeat (8) @(negedge clk_sys);
            check(8'(rx_cnt - n), 8'h01, "rx count");
            check(rx_last, b, "rx byte");
            mio_host_model_inst.frame(1'b0);
        end
        // fill fifo, host clock still
        n = 0;
        @(negedge clk_sys);
        tx_valid = 1'b1;
        while (tx_ready === 1'b1 && n < 40) begin
            b = (n == 0) ? 8'h00 : (n == 1) ? 8'hff : 8'($urandom);
            tx_data = b;
            q.push_back(b);
            @(negedge clk_sys);
            n++;
        end
        tx_valid = 1'b0;
        check(8'(n), 8'(FIFO_DEPTH), "fifo depth");
        cfg1_volatile_reg = 8'h02;
        cmd = '{MIO_W4, 1'b0, 1'b1};
        mio_host_model_inst.frame(1'b1);
        check({4'h0, pad.oe}, exp_oe(MIO_W4, 1'b1), "quad enables");
        while (q.size() > 0) begin
            mio_host_model_inst.recv(4, 1'b0, got);
            check(got, q.pop_front(), "quad tx byte");
        end
        n = und_cnt;
        mio_host_model_inst.recv(4, 1'b0, got);
        check({7'h00, und_cnt > n}, 8'h01, "underrun");
        mio_host_model_inst.frame(1'b0);
        check({4'h0, pad.oe}, 8'h00, "released");
        for (int k = 0; k < 2; k++) begin
            cfg1_volatile_reg = 8'h00;
            cmd = '{wd[k], k == 1, 1'b1};
            b = 8'($urandom);
            push(b);
            mio_host_model_inst.frame(1'b1);
            check({4'h0, pad.oe}, exp_oe(wd[k], 1'b0), "enables");
            mio_host_model_inst.recv(ln[k], k == 1, got);
            check(got, b, "tx byte");
            mio_host_model_inst.frame(1'b0);
        end
        cmd = '{MIO_W1, 1'b0, 1'b0};
        mio_host_model_inst.frame(1'b1);
        for (int k = 0; k < 24; k++) begin
            @(negedge clk_sys);
            cfg1_volatile_reg = {6'($urandom), k[2], 1'($urandom)};
            status1_nonvolatile_reg = {k[1], 7'($urandom)};
            write_registers_cmd = k < 8;
            write_any_register_cmd = k >= 8;
            wrany_hits_sr1_cfg1 = (k < 8) ? 1'($urandom) : k < 16;
            mio_host_model_inst.side_pins(k[0], 1'b1);
            repeat (6) @(negedge clk_sys);
            check({7'h00, reg_write_ignore}, exp_ign(k), "write filter");
            check({7'h00, wp_n_level}, {7'h00, k[2] || !k[1] || k[0]}, "wp level");
        end
        {write_registers_cmd, write_any_register_cmd} = 2'h0;
        mio_host_model_inst.frame(1'b0);
        cfg2_volatile_reg = {2'($urandom), 1'b1, 5'($urandom)};
        for (int k = 0; k < 3; k++) begin
            n = rst_cnt;
            cfg1_volatile_reg = {6'h00, k == 2, 1'b0};
            if (k == 2) mio_host_model_inst.frame(1'b1);
            mio_host_model_inst.side_pins(1'b1, 1'b0);
            repeat (k == 0 ? TRP_CYC - 5 : TRP_CYC + 10) @(negedge clk_sys);
            mio_host_model_inst.side_pins(1'b1, 1'b1);
            repeat (6) @(negedge clk_sys);
            check(8'(rst_cnt - n), {7'h00, k == 1}, "reset pulses");
            if (k == 2) mio_host_model_inst.frame(1'b0);
        end
        stop_test();
    end
endmodule
